// ---- ethernet_irq_combiner.sv ----
// Interrupt sourcing, status registers and per-core level-to-pulse combiner
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ethernet_irq_combiner_params.svh"

module ethernet_irq_combiner (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // MAC level sources
    input wire ethernet_irq_combiner_pkg::mac_source_type mac_source_i,
    // Descriptor error events from the DMA engines
    input wire ethernet_irq_combiner_pkg::desc_error_type desc_error_i,
    // Management unit status
    input wire logic [`EIC_PHY_COUNT-1:0] phy_link_state_i,
    input wire logic [`EIC_PORT_COUNT-1:0] user_access_pending_i,
    // Frame activity for debug suspend
    input wire logic rx_frame_active_i,
    input wire logic tx_frame_active_i,
    input wire logic tx_fifo_frame_pending_i,
    input wire logic rx_frame_detect_i,
    // Frame control outputs
    output logic frame_start_allow_o,
    output logic tx_send_allow_o,
    output logic rx_frame_ignore_o,
    output logic stats_update_enable_o,
    // Interrupt levels
    output logic descriptor_error_irq_o,
    output logic link_change_irq_o,
    output logic user_done_irq_o,
    // Per-core pulse outputs
    output logic [`EIC_CORE_COUNT-1:0] common_group_irq_out_o,
    output logic [`EIC_CORE_COUNT-1:0] tx_group_irq_out_o,
    output logic [`EIC_CORE_COUNT-1:0] rx_group_irq_out_o,
    // Pacing configuration to the pacing engines
    output logic [`EIC_PACE_COUNT-1:0][11:0] pace_delay_value_o,
    output logic [`EIC_PACE_COUNT-1:0][7:0] divider_value_o,
    output logic [`EIC_PACE_COUNT-1:0] delay_counter_reset_o,
    output logic [`EIC_PACE_COUNT-1:0] divider_count_reset_o
);

    ethernet_irq_combiner_pkg::state_type s_reg;
    ethernet_irq_combiner_pkg::state_type s_next;

    logic [1:0] mac_raw;
    logic [1:0] mac_masked;
    logic [`EIC_PORT_COUNT-1:0] link_masked;
    logic [`EIC_PORT_COUNT-1:0] user_masked;
    logic [`EIC_SOURCE_WIDTH-1:0] sources;
    logic [19:0] vector;
    logic access_write;
    logic access_setup;

    // Index of a core enable register, or CORE_COUNT when none is hit
    function automatic logic [3:0] core_index(input logic [11:0] addr);
        logic [3:0] idx;
        idx = 4'(`EIC_CORE_COUNT);
        for (int i = 0; i < `EIC_CORE_COUNT; i++) begin
            if (addr == 12'(`EIC_CORE_ENABLE_BASE + 4 * i)) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : core_index

    // Index of a pacing register, or PACE_COUNT when none is hit
    function automatic logic [3:0] pace_index(input logic [11:0] addr);
        logic [3:0] idx;
        idx = 4'(`EIC_PACE_COUNT);
        for (int i = 0; i < `EIC_PACE_COUNT; i++) begin
            if (addr == 12'(`EIC_PACE_BASE + 4 * i)) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : pace_index

    // Phy select register image
    function automatic logic [31:0] phy_select_word(input logic [4:0] addr, input logic en);
        logic [31:0] w;
        w = 32'h00000000;
        w[`EIC_PHY_ADDR_LSB +: `EIC_PHY_ADDR_WIDTH] = addr;
        w[`EIC_LINK_ENABLE_BIT] = en;
        return w;
    endfunction : phy_select_word

    // Derived status
    always_comb begin
        mac_raw = '0;
        mac_raw[`EIC_STAT_BIT] = mac_source_i.counter_overflow_irq;
        mac_raw[`EIC_DESC_BIT] = s_reg.desc_raw_reg;
        mac_masked = mac_raw & s_reg.mac_mask_reg;
        link_masked = s_reg.link_raw_reg & s_reg.link_en_reg;
        user_masked = s_reg.user_raw_reg & s_reg.user_mask_reg;
        sources = '0;
        sources[`EIC_EN_DESC_BIT] = mac_masked[`EIC_DESC_BIT];
        sources[`EIC_EN_STAT_BIT] = mac_masked[`EIC_STAT_BIT];
        sources[`EIC_EN_LINK_BIT] = |link_masked;
        sources[`EIC_EN_USER_BIT] = |user_masked;
        sources[`EIC_EN_TX_MSB:`EIC_EN_TX_LSB] = mac_source_i.tx_channel_done_irq;
        sources[`EIC_EN_RX_MSB:`EIC_EN_RX_LSB] = mac_source_i.rx_channel_done_irq;
        vector = '0;
        vector[`EIC_VEC_TX_LSB +: 8] = mac_source_i.tx_channel_done_irq;
        vector[`EIC_VEC_RX_LSB +: 8] = mac_source_i.rx_channel_done_irq;
        vector[`EIC_VEC_STAT_BIT] = mac_masked[`EIC_STAT_BIT];
        vector[`EIC_VEC_DESC_BIT] = mac_masked[`EIC_DESC_BIT];
        vector[`EIC_VEC_LINK_BIT] = |link_masked;
        vector[`EIC_VEC_USER_BIT] = |user_masked;
        access_write = psel_i & penable_i & pwrite_i;
        access_setup = psel_i & ~penable_i;
    end

    // Next state
    always_comb begin
        logic [31:0] rd;
        logic hit;
        logic [3:0] ci;
        logic [3:0] pi;
        logic cur_link;
        logic suspend_req;
        logic frames_idle;
        logic [2:0] level;
        rd = 32'h00000000;
        hit = 1'b1;
        ci = core_index(paddr_i);
        pi = pace_index(paddr_i);
        cur_link = 1'b0;
        suspend_req = 1'b0;
        frames_idle = 1'b0;
        level = 3'b000;
        s_next = s_reg;
        s_next.pace_timer_reset_reg = '0;
        s_next.pace_count_reset_reg = '0;

        // Read data is captured in the setup phase
        case (paddr_i)
            `EIC_MAC_RAW_OFFSET: rd[1:0] = mac_raw;
            `EIC_MAC_MASKED_OFFSET: rd[1:0] = mac_masked;
            `EIC_MAC_MASK_SET_OFFSET: rd[1:0] = s_reg.mac_mask_reg;
            `EIC_MAC_MASK_CLEAR_OFFSET: rd[1:0] = s_reg.mac_mask_reg;
            `EIC_DESC_CAUSE_OFFSET: rd[7:0] = s_reg.desc_cause_reg;
            `EIC_PHY_SELECT0_OFFSET: begin
                rd = phy_select_word(s_reg.phy_addr_reg[0], s_reg.link_en_reg[0]);
            end
            `EIC_PHY_SELECT1_OFFSET: begin
                rd = phy_select_word(s_reg.phy_addr_reg[1], s_reg.link_en_reg[1]);
            end
            `EIC_LINK_RAW_OFFSET: rd[1:0] = s_reg.link_raw_reg;
            `EIC_LINK_MASKED_OFFSET: rd[1:0] = link_masked;
            `EIC_USER_RAW_OFFSET: rd[1:0] = s_reg.user_raw_reg;
            `EIC_USER_MASKED_OFFSET: rd[1:0] = user_masked;
            `EIC_USER_MASK_SET_OFFSET: rd[1:0] = s_reg.user_mask_reg;
            `EIC_USER_MASK_CLEAR_OFFSET: rd[1:0] = s_reg.user_mask_reg;
            `EIC_VECTOR_OFFSET: rd[19:0] = vector;
            `EIC_DEBUG_CONTROL_OFFSET: begin
                rd[`EIC_HALT_BIT] = s_reg.halt_reg;
                rd[`EIC_RUN_BIT] = s_reg.run_reg;
            end
            default: begin
                if (ci != 4'(`EIC_CORE_COUNT)) begin
                    rd[23:0] = s_reg.core_en_reg[ci[2:0]];
                end else if (pi != 4'(`EIC_PACE_COUNT)) begin
                    rd[`EIC_PACE_DELAY_MSB:`EIC_PACE_DELAY_LSB] = s_reg.pace_delay_reg[pi[2:0]];
                    rd[`EIC_PACE_DIV_MSB:`EIC_PACE_DIV_LSB] = s_reg.pace_div_reg[pi[2:0]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        if (access_setup) begin
            s_next.rdata_reg = rd;
            s_next.err_reg = ~hit;
        end

        // Register writes take effect in the access phase
        if (access_write) begin
            case (paddr_i)
                `EIC_MAC_MASK_SET_OFFSET: begin
                    s_next.mac_mask_reg = s_reg.mac_mask_reg | pwdata_i[1:0];
                end
                `EIC_MAC_MASK_CLEAR_OFFSET: begin
                    s_next.mac_mask_reg = s_reg.mac_mask_reg & ~pwdata_i[1:0];
                end
                `EIC_PHY_SELECT0_OFFSET: begin
                    s_next.phy_addr_reg[0] = pwdata_i[`EIC_PHY_ADDR_LSB +: `EIC_PHY_ADDR_WIDTH];
                    s_next.link_en_reg[0] = pwdata_i[`EIC_LINK_ENABLE_BIT];
                end
                `EIC_PHY_SELECT1_OFFSET: begin
                    s_next.phy_addr_reg[1] = pwdata_i[`EIC_PHY_ADDR_LSB +: `EIC_PHY_ADDR_WIDTH];
                    s_next.link_en_reg[1] = pwdata_i[`EIC_LINK_ENABLE_BIT];
                end
                `EIC_LINK_MASKED_OFFSET: begin
                    s_next.link_raw_reg = s_reg.link_raw_reg & ~pwdata_i[1:0];
                end
                `EIC_USER_MASKED_OFFSET: begin
                    s_next.user_raw_reg = s_reg.user_raw_reg & ~pwdata_i[1:0];
                end
                `EIC_USER_MASK_SET_OFFSET: begin
                    s_next.user_mask_reg = s_reg.user_mask_reg | pwdata_i[1:0];
                end
                `EIC_USER_MASK_CLEAR_OFFSET: begin
                    s_next.user_mask_reg = s_reg.user_mask_reg & ~pwdata_i[1:0];
                end
                `EIC_DEBUG_CONTROL_OFFSET: begin
                    s_next.halt_reg = pwdata_i[`EIC_HALT_BIT];
                    s_next.run_reg = pwdata_i[`EIC_RUN_BIT];
                end
                default: begin
                    if (ci != 4'(`EIC_CORE_COUNT)) begin
                        s_next.core_en_reg[ci[2:0]] = '0;
                        s_next.core_en_reg[ci[2:0]][`EIC_EN_COMMON_MSB:`EIC_EN_COMMON_LSB] =
                            pwdata_i[`EIC_EN_COMMON_MSB:`EIC_EN_COMMON_LSB];
                        s_next.core_en_reg[ci[2:0]][`EIC_EN_TX_MSB:`EIC_EN_TX_LSB] =
                            pwdata_i[`EIC_EN_TX_MSB:`EIC_EN_TX_LSB];
                        s_next.core_en_reg[ci[2:0]][`EIC_EN_RX_MSB:`EIC_EN_RX_LSB] =
                            pwdata_i[`EIC_EN_RX_MSB:`EIC_EN_RX_LSB];
                    end else if (pi != 4'(`EIC_PACE_COUNT)) begin
                        if (pwdata_i[`EIC_PACE_DELAY_UPDATE_BIT]) begin
                            s_next.pace_delay_reg[pi[2:0]] =
                                pwdata_i[`EIC_PACE_DELAY_MSB:`EIC_PACE_DELAY_LSB];
                        end
                        if (pwdata_i[`EIC_PACE_DIV_UPDATE_BIT]) begin
                            s_next.pace_div_reg[pi[2:0]] =
                                pwdata_i[`EIC_PACE_DIV_MSB:`EIC_PACE_DIV_LSB];
                        end
                        s_next.pace_timer_reset_reg[pi[2:0]] =
                            pwdata_i[`EIC_PACE_TIMER_RESET_BIT];
                        s_next.pace_count_reset_reg[pi[2:0]] =
                            pwdata_i[`EIC_PACE_COUNT_RESET_BIT];
                    end
                end
            endcase
        end

        // Descriptor errors are sticky; only reset clears them
        if (|desc_error_i) begin
            s_next.desc_raw_reg = 1'b1;
        end
        s_next.desc_cause_reg.tx_cause = s_reg.desc_cause_reg.tx_cause |
            desc_error_i.tx_cause;
        s_next.desc_cause_reg.rx_cause = s_reg.desc_cause_reg.rx_cause |
            desc_error_i.rx_cause;

        // Link change on the monitored PHY; a new event wins over a clear
        for (int i = 0; i < `EIC_PORT_COUNT; i++) begin
            cur_link = phy_link_state_i[s_reg.phy_addr_reg[i]];
            s_next.link_prev_reg[i] = cur_link;
            if (s_reg.link_en_reg[i] && (cur_link != s_reg.link_prev_reg[i])) begin
                s_next.link_raw_reg[i] = 1'b1;
            end
        end

        // User access completion on a falling pending bit
        for (int i = 0; i < `EIC_PORT_COUNT; i++) begin
            s_next.user_prev_reg[i] = user_access_pending_i[i];
            if (s_reg.user_prev_reg[i] && !user_access_pending_i[i]) begin
                s_next.user_raw_reg[i] = 1'b1;
            end
        end

        // Per-core combiner: gated group levels become one-cycle pulses
        for (int c = 0; c < `EIC_CORE_COUNT; c++) begin
            level[0] = |(sources[`EIC_EN_COMMON_MSB:`EIC_EN_COMMON_LSB] &
                s_reg.core_en_reg[c][`EIC_EN_COMMON_MSB:`EIC_EN_COMMON_LSB]);
            level[1] = |(sources[`EIC_EN_TX_MSB:`EIC_EN_TX_LSB] &
                s_reg.core_en_reg[c][`EIC_EN_TX_MSB:`EIC_EN_TX_LSB]);
            level[2] = |(sources[`EIC_EN_RX_MSB:`EIC_EN_RX_LSB] &
                s_reg.core_en_reg[c][`EIC_EN_RX_MSB:`EIC_EN_RX_LSB]);
            s_next.group_prev_reg[c] = level;
            s_next.pulse_reg[c] = level & ~s_reg.group_prev_reg[c];
        end

        // Debug suspend sequencing
        suspend_req = s_reg.halt_reg & ~s_reg.run_reg;
        frames_idle = ~rx_frame_active_i & ~tx_frame_active_i;
        unique case (s_reg.mode_reg)
            ethernet_irq_combiner_pkg::normal_state: begin
                if (suspend_req) begin
                    s_next.mode_reg = frames_idle ? ethernet_irq_combiner_pkg::suspended_state
                        : ethernet_irq_combiner_pkg::draining_state;
                end
            end
            ethernet_irq_combiner_pkg::draining_state: begin
                if (!suspend_req) begin
                    s_next.mode_reg = ethernet_irq_combiner_pkg::normal_state;
                end else if (frames_idle) begin
                    s_next.mode_reg = ethernet_irq_combiner_pkg::suspended_state;
                end
            end
            ethernet_irq_combiner_pkg::suspended_state: begin
                if (!suspend_req) begin
                    s_next.mode_reg = ethernet_irq_combiner_pkg::normal_state;
                end
            end
            default: begin
                s_next.mode_reg = ethernet_irq_combiner_pkg::normal_state;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_reg <= '0;
            s_reg.core_en_reg <= {`EIC_CORE_COUNT{`EIC_CORE_ENABLE_RESET}};
            s_reg.pace_delay_reg <= {`EIC_PACE_COUNT{`EIC_PACE_DELAY_RESET}};
            s_reg.pace_div_reg <= {`EIC_PACE_COUNT{`EIC_PACE_DIV_RESET}};
            s_reg.mode_reg <= ethernet_irq_combiner_pkg::normal_state;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    always_comb begin
        prdata_o = s_reg.rdata_reg;
        pready_o = 1'b1;
        pslverr_o = psel_i & penable_i & s_reg.err_reg;
        descriptor_error_irq_o = mac_masked[`EIC_DESC_BIT];
        link_change_irq_o = |link_masked;
        user_done_irq_o = |user_masked;
        for (int c = 0; c < `EIC_CORE_COUNT; c++) begin
            common_group_irq_out_o[c] = s_reg.pulse_reg[c][0];
            tx_group_irq_out_o[c] = s_reg.pulse_reg[c][1];
            rx_group_irq_out_o[c] = s_reg.pulse_reg[c][2];
        end
        frame_start_allow_o = (s_reg.mode_reg == ethernet_irq_combiner_pkg::normal_state);
        tx_send_allow_o = frame_start_allow_o | tx_fifo_frame_pending_i;
        rx_frame_ignore_o = ~frame_start_allow_o & rx_frame_detect_i;
        stats_update_enable_o = ~rx_frame_ignore_o;
        pace_delay_value_o = s_reg.pace_delay_reg;
        divider_value_o = s_reg.pace_div_reg;
        delay_counter_reset_o = s_reg.pace_timer_reset_reg;
        divider_count_reset_o = s_reg.pace_count_reset_reg;
    end

endmodule : ethernet_irq_combiner

`default_nettype wire

// ---- ethernet_irq_combiner_params.svh ----
// Offsets, field positions, reset values and counts of the interrupt combiner
`ifndef ETHERNET_IRQ_COMBINER_PARAMS_SVH
`define ETHERNET_IRQ_COMBINER_PARAMS_SVH

// Counts
`define EIC_CORE_COUNT 6
`define EIC_PACE_COUNT 8
`define EIC_CHANNEL_COUNT 8
`define EIC_PORT_COUNT 2
`define EIC_PHY_ADDR_WIDTH 5
`define EIC_PHY_COUNT 32
`define EIC_TX_CAUSE_COUNT 6
`define EIC_RX_CAUSE_COUNT 2
`define EIC_SOURCE_WIDTH 24

// Register byte offsets
`define EIC_MAC_RAW_OFFSET 12'h000
`define EIC_MAC_MASKED_OFFSET 12'h004
`define EIC_MAC_MASK_SET_OFFSET 12'h008
`define EIC_MAC_MASK_CLEAR_OFFSET 12'h00c
`define EIC_DESC_CAUSE_OFFSET 12'h010
`define EIC_PHY_SELECT0_OFFSET 12'h014
`define EIC_PHY_SELECT1_OFFSET 12'h018
`define EIC_LINK_RAW_OFFSET 12'h01c
`define EIC_LINK_MASKED_OFFSET 12'h020
`define EIC_USER_RAW_OFFSET 12'h024
`define EIC_USER_MASKED_OFFSET 12'h028
`define EIC_USER_MASK_SET_OFFSET 12'h02c
`define EIC_USER_MASK_CLEAR_OFFSET 12'h030
`define EIC_VECTOR_OFFSET 12'h034
`define EIC_DEBUG_CONTROL_OFFSET 12'h038
`define EIC_CORE_ENABLE_BASE 12'h040
`define EIC_PACE_BASE 12'h080

// MAC status and mask fields
`define EIC_STAT_BIT 0
`define EIC_DESC_BIT 1

// Phy select fields
`define EIC_PHY_ADDR_LSB 0
`define EIC_LINK_ENABLE_BIT 6

// Debug control fields
`define EIC_HALT_BIT 0
`define EIC_RUN_BIT 1

// Core enable fields
`define EIC_EN_DESC_BIT 1
`define EIC_EN_STAT_BIT 2
`define EIC_EN_LINK_BIT 3
`define EIC_EN_USER_BIT 4
`define EIC_EN_COMMON_MSB 4
`define EIC_EN_COMMON_LSB 1
`define EIC_EN_TX_MSB 15
`define EIC_EN_TX_LSB 8
`define EIC_EN_RX_MSB 23
`define EIC_EN_RX_LSB 16
`define EIC_CORE_ENABLE_RESET 24'h000000

// Vector fields
`define EIC_VEC_TX_LSB 0
`define EIC_VEC_RX_LSB 8
`define EIC_VEC_STAT_BIT 16
`define EIC_VEC_DESC_BIT 17
`define EIC_VEC_LINK_BIT 18
`define EIC_VEC_USER_BIT 19

// Pacing fields
`define EIC_PACE_DELAY_MSB 27
`define EIC_PACE_DELAY_LSB 16
`define EIC_PACE_DIV_MSB 15
`define EIC_PACE_DIV_LSB 8
`define EIC_PACE_DELAY_UPDATE_BIT 3
`define EIC_PACE_DIV_UPDATE_BIT 2
`define EIC_PACE_TIMER_RESET_BIT 1
`define EIC_PACE_COUNT_RESET_BIT 0
`define EIC_PACE_DELAY_RESET 12'h000
`define EIC_PACE_DIV_RESET 8'h00

`endif

// ---- ethernet_irq_combiner_pkg.sv ----
// Types shared by the interrupt combiner
`include "ethernet_irq_combiner_params.svh"

package ethernet_irq_combiner_pkg;

    typedef enum logic [1:0] {
        normal_state,
        draining_state,
        suspended_state
    } debug_mode_type;

    typedef struct packed {
        logic [`EIC_CHANNEL_COUNT-1:0] tx_channel_done_irq;
        logic [`EIC_CHANNEL_COUNT-1:0] rx_channel_done_irq;
        logic counter_overflow_irq;
    } mac_source_type;

    typedef struct packed {
        logic [`EIC_TX_CAUSE_COUNT-1:0] tx_cause;
        logic [`EIC_RX_CAUSE_COUNT-1:0] rx_cause;
    } desc_error_type;

    typedef struct packed {
        logic [31:0] rdata_reg;
        logic err_reg;
        logic [1:0] mac_mask_reg;
        logic desc_raw_reg;
        desc_error_type desc_cause_reg;
        logic [`EIC_PORT_COUNT-1:0][`EIC_PHY_ADDR_WIDTH-1:0] phy_addr_reg;
        logic [`EIC_PORT_COUNT-1:0] link_en_reg;
        logic [`EIC_PORT_COUNT-1:0] link_prev_reg;
        logic [`EIC_PORT_COUNT-1:0] link_raw_reg;
        logic [`EIC_PORT_COUNT-1:0] user_mask_reg;
        logic [`EIC_PORT_COUNT-1:0] user_prev_reg;
        logic [`EIC_PORT_COUNT-1:0] user_raw_reg;
        logic halt_reg;
        logic run_reg;
        debug_mode_type mode_reg;
        logic [`EIC_CORE_COUNT-1:0][`EIC_SOURCE_WIDTH-1:0] core_en_reg;
        logic [`EIC_CORE_COUNT-1:0][2:0] group_prev_reg;
        logic [`EIC_CORE_COUNT-1:0][2:0] pulse_reg;
        logic [`EIC_PACE_COUNT-1:0][11:0] pace_delay_reg;
        logic [`EIC_PACE_COUNT-1:0][7:0] pace_div_reg;
        logic [`EIC_PACE_COUNT-1:0] pace_timer_reset_reg;
        logic [`EIC_PACE_COUNT-1:0] pace_count_reset_reg;
    } state_type;

endpackage : ethernet_irq_combiner_pkg

// ---- ethernet_irq_combiner_assertions.sv ----
// Port-level assertions for the interrupt combiner
`timescale 1ns/1ps
`default_nettype none
`include "ethernet_irq_combiner_params.svh"
module irq_combiner_checker (
    // Clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire ethernet_irq_combiner_pkg::mac_source_type mac_source_i,
    input wire logic rx_frame_detect_i,
    input wire logic tx_fifo_frame_pending_i,
    // Outputs
    input wire logic descriptor_error_irq_o,
    input wire logic link_change_irq_o,
    input wire logic user_done_irq_o,
    input wire logic frame_start_allow_o,
    input wire logic tx_send_allow_o,
    input wire logic rx_frame_ignore_o,
    input wire logic [`EIC_CORE_COUNT-1:0] common_group_irq_out_o,
    input wire logic [`EIC_CORE_COUNT-1:0] tx_group_irq_out_o,
    input wire logic [`EIC_CORE_COUNT-1:0] rx_group_irq_out_o
);
    logic clear_wr;
    logic common_src;
    assign clear_wr = psel_i && penable_i && pwrite_i && paddr_i == `EIC_MAC_MASK_CLEAR_OFFSET;
    assign common_src = descriptor_error_irq_o || link_change_irq_o || user_done_irq_o
        || mac_source_i.counter_overflow_irq;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence one_cycle(s);
        s ##1 !s;
    endsequence
    desc_sticky_a: assert property (descriptor_error_irq_o && !clear_wr
        |=> descriptor_error_irq_o) else $error("descriptor error dropped");
    common_pulse_a: assert property ($rose(common_group_irq_out_o[0])
        |-> one_cycle(common_group_irq_out_o[0])) else $error("common pulse too long");
    group_pulse_a: assert property (((tx_group_irq_out_o & $past(tx_group_irq_out_o))
        | (rx_group_irq_out_o & $past(rx_group_irq_out_o))) == 6'h0) else $error("pulse held");
    tx_cause_a: assert property (tx_group_irq_out_o != 6'h0
        |-> $past(mac_source_i.tx_channel_done_irq) != 8'h0) else $error("tx pulse uncaused");
    rx_cause_a: assert property (rx_group_irq_out_o != 6'h0
        |-> $past(mac_source_i.rx_channel_done_irq) != 8'h0) else $error("rx pulse uncaused");
    common_cause_a: assert property (common_group_irq_out_o != 6'h0
        |-> $past(common_src)) else $error("common pulse uncaused");
    tx_drain_a: assert property (tx_fifo_frame_pending_i
        |-> tx_send_allow_o) else $error("fifo frame held back");
    ignore_only_a: assert property (rx_frame_ignore_o
        == (rx_frame_detect_i && !frame_start_allow_o)) else $error("ignore wrong");
endmodule : irq_combiner_checker
`default_nettype wire

// ---- cpu_irq_model.sv ----
// Model of the core interrupt selector counting pulses per core and group
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Per-core pulses
    input wire logic [5:0] common_i,
    input wire logic [5:0] tx_i,
    input wire logic [5:0] rx_i,
    // Counts: index 0 common, 1 transmit, 2 receive
    output logic [5:0][2:0][7:0] count_o
);
    always_ff @(posedge ref_clk_i) begin
        for (int c = 0; c < 6; c++) begin
            if (reset_i) count_o[c] <= '0;
            else count_o[c] <= count_o[c] + {8'(rx_i[c]), 8'(tx_i[c]), 8'(common_i[c])};
        end
    end
endmodule : cpu_irq_model
`default_nettype wire

// ---- ethernet_irq_combiner_test.sv ----
// Self-checking bench for the interrupt combiner
`timescale 1ns/1ps
`default_nettype none
module ethernet_irq_combiner_test;
    logic ref_clk_i = '0, reset_i = '1, psel_i = '0, penable_i = '0, pwrite_i = '0, err;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, phy_link_state_i = '0, prdata_o, rd;
    logic pready_o, pslverr_o, frame_start_allow_o, tx_send_allow_o, rx_frame_ignore_o;
    logic stats_update_enable_o, descriptor_error_irq_o, link_change_irq_o, user_done_irq_o;
    logic [5:0] common_group_irq_out_o, tx_group_irq_out_o, rx_group_irq_out_o;
    logic [7:0][11:0] pace_delay_value_o;
    logic [7:0][7:0] divider_value_o;
    logic [7:0] delay_counter_reset_o, divider_count_reset_o;
    ethernet_irq_combiner_pkg::mac_source_type mac_source_i = '0;
    ethernet_irq_combiner_pkg::desc_error_type desc_error_i = '0;
    logic [1:0] user_access_pending_i = 2'h3;
    logic rx_frame_active_i = '0, tx_frame_active_i = '0;
    logic tx_fifo_frame_pending_i = '1, rx_frame_detect_i = '1;
    logic [5:0][2:0][7:0] count;
    int miscompares = 0, total_checks = 0;
    logic [75:0] rows [5] = '{{12'h054, 32'hffffffff, 32'h00ffff1e},
        {12'h080, 32'hfabcde0f, 32'h0abcde00}, {12'h084, 32'h01234500, 32'h0},
        {12'h088, 32'h00003404, 32'h00003400}, {12'hffc, 32'hffffffff, 32'h0}};
    ethernet_irq_combiner DUT (.*);
    cpu_irq_model model (.ref_clk_i, .reset_i, .common_i(common_group_irq_out_o),
        .tx_i(tx_group_irq_out_o), .rx_i(rx_group_irq_out_o), .count_o(count));
    always #25 ref_clk_i = ~ref_clk_i;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel_i <= '1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= '1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 16);
        if (pready_o !== 1'h1) begin
            miscompares++;
            report_and_stop();
        end else begin
            rd = prdata_o;
            err = pslverr_o;
            psel_i <= '0;
            penable_i <= '0;
        end
    endtask : apb
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb('0, a, '0);
        check("read", rd, e);
    endtask : rd_chk
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_i <= '0;
        for (int i = 0; i < 5; i++) begin
            rd_chk(rows[i][75:64], 32'h0);
            apb('1, rows[i][75:64], rows[i][63:32]);
            rd_chk(rows[i][75:64], rows[i][31:0]);
        end
        check("slverr", 32'(err), 32'h1);
        apb('1, 12'h040, 32'h2);
        apb('1, 12'h008, 32'h2);
        for (int k = 0; k < 8; k++) begin
            desc_error_i <= 8'(1 << k);
            @(posedge ref_clk_i);
            desc_error_i <= '0;
            rd_chk(12'h010, 32'((2 << k) - 1));
        end
        check("desc_irq", 32'(descriptor_error_irq_o), 32'h1);
        apb('1, 12'h00c, 32'h2);
        rd_chk(12'h000, 32'h2);
        rd_chk(12'h004, 32'h0);
        check("core1", 32'(count[1][0]), 32'h0);
        apb('1, 12'h040, 32'h12);
        apb('1, 12'h02c, 32'h1);
        user_access_pending_i <= 2'h2;
        repeat (3) @(posedge ref_clk_i);
        user_access_pending_i <= 2'h0;
        check("user_irq", 32'(user_done_irq_o), 32'h1);
        rd_chk(12'h024, 32'h3);
        rd_chk(12'h028, 32'h1);
        apb('1, 12'h028, 32'h1);
        rd_chk(12'h028, 32'h0);
        check("common", 32'(count[0][0]), 32'h2);
        apb('1, 12'h014, 32'h45);
        phy_link_state_i <= 32'ha0;
        rd_chk(12'h01c, 32'h1);
        check("link_irq", 32'(link_change_irq_o), 32'h1);
        apb('1, 12'h020, 32'h1);
        rd_chk(12'h01c, 32'h0);
        apb('1, 12'h040, 32'h100);
        mac_source_i <= 17'h00602;
        rd_chk(12'h034, 32'h103);
        check("rx_cnt", 32'(count[0][2]), 32'h0);
        apb('1, 12'h040, 32'h0);
        apb('1, 12'h040, 32'h100);
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check("tx_cnt", 32'(count[0][1]), 32'h2);
        tx_fifo_frame_pending_i <= '0;
        for (int m = 0; m < 4; m++) begin
            apb('1, 12'h038, 32'(m));
            repeat (2) @(negedge ref_clk_i);
            check("normal", 32'(frame_start_allow_o), 32'(m != 1));
            check("ignore", 32'(rx_frame_ignore_o), 32'(m == 1));
            check("stats", 32'(stats_update_enable_o), 32'(m != 1));
            check("tx_send", 32'(tx_send_allow_o), 32'(m != 1));
        end
        apb('1, 12'h080, 32'h3);
        #1;
        check("pace_rst", 32'({delay_counter_reset_o[0], divider_count_reset_o[0]}), 32'h3);
        check("delay", 32'(pace_delay_value_o[0]), 32'habc);
        check("divider", 32'(divider_value_o[2]), 32'h34);
        reset_i <= '1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= '0;
        rd_chk(12'h000, 32'h0);
        rd_chk(12'h054, 32'h0);
        rd_chk(12'h080, 32'h0);
        report_and_stop();
    end
endmodule : ethernet_irq_combiner_test
bind ethernet_irq_combiner irq_combiner_checker chk (.*);
`default_nettype wire
